// ===== common/hbsfe_pkg.sv
// Constants and types shared by the host bus strobe front end.
package hbsfe_pkg;
  // ---------------------------------------------------------------
  // Synchronised pin vector layout
  // ---------------------------------------------------------------
  localparam int NPIN = 22;
  localparam int PIN_SHIFT = 0;
  localparam int PIN_RDRW = 1;
  localparam int PIN_WRDS = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_EDGE = 4;
  localparam int PIN_AD = 5;
  localparam int PIN_A = 13;
  localparam int PIN_HW = 18;
  localparam int PIN_STYLE = 19;
  localparam int PIN_MUX = 21;
  localparam logic [NPIN-1:0] PIN_IDLE = 22'h3F_FFFF;
  // ---------------------------------------------------------------
  // Bus widths and serial framing
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int CMD_RW_BIT = 7;
  localparam logic [4:0] SER_CMD_LAST = 5'h07;
  localparam logic [4:0] SER_HALF = 5'h08;
  localparam logic [4:0] SER_LAST = 5'h0F;
  localparam logic [4:0] SER_BITS = 5'h10;
  localparam logic [4:0] SER_CNT_RST = 5'h00;
  localparam logic [15:0] SER_SHIFT_RST = 16'h0000;
  localparam logic [1:0] CFG_SETTLE = 2'h3;
  localparam logic [1:0] STY_PIN_SERIAL = 2'h0;
  localparam logic [1:0] STY_PIN_PAIR = 2'h1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  typedef enum logic [1:0] {STYLE_SERIAL, STYLE_PAIR, STYLE_DS} hbsfe_style_t;
endpackage

// ===== common/hbsfe_pin_if.sv
// Synchronised pin levels and edges passed from the sampler to the core.
`timescale 1ns/1ps
interface hbsfe_pin_if;
  import hbsfe_pkg::*;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  modport src(output lvl, output rise, output fall);
  modport dst(input lvl, input rise, input fall);
endinterface

// ===== hw/hbsfe_pin_sync.sv
// Two-flop synchroniser and edge finder for every host pin.
`timescale 1ns/1ps
module hbsfe_pin_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [hbsfe_pkg::NPIN-1:0] pins_raw,
  hbsfe_pin_if.src p
);
  import hbsfe_pkg::*;
  logic [NPIN-1:0] meta_reg;
  logic [NPIN-1:0] sync_reg;
  logic [NPIN-1:0] prev_reg;

  // Idle value is all ones so that no false rising edge appears after reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= PIN_IDLE;
      sync_reg <= PIN_IDLE;
      prev_reg <= PIN_IDLE;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign p.lvl = sync_reg;
  assign p.rise = sync_reg & ~prev_reg;
  assign p.fall = ~sync_reg & prev_reg;
endmodule // hbsfe_pin_sync

// ===== hw/hbsfe_top.sv
// Host interface strobe front end: serial, strobe-pair and data-strobe.
// Notes on behaviour
// - Serial output launches on falling shift edge if edge select high, else rising.
// - Serial input is sampled on rising shift edges whatever the edge select.
// - Strobe-pair muxed: low five bus bits latched on latch strobe fall.
// - Data-strobe muxed: low five bus bits latched on address strobe fall.
// - Hardware control mode ignores shift/strobe and read/select pins completely.
// - Strobe-pair: write data captured on write strobe rising edge.
// - Data-strobe write: data captured on data strobe rising edge.
// - Serial write: output high impedance eight bits, then driven low eight.
`timescale 1ns/1ps
module hbsfe_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic host_select_n,
  input wire logic shift_addr_strobe_n,
  input wire logic read_rw_select,
  input wire logic serial_in_data_strobe_n,
  input wire logic out_edge_select,
  input wire logic hw_control_mode,
  input wire logic [1:0] host_style,
  input wire logic addr_muxed,
  input wire logic [hbsfe_pkg::DATA_W-1:0] bus_in,
  output logic [hbsfe_pkg::DATA_W-1:0] bus_out,
  output logic bus_oe,
  input wire logic [hbsfe_pkg::ADDR_W-1:0] addr_in,
  output logic serial_out_line,
  output logic serial_out_oe,
  output logic [hbsfe_pkg::ADDR_W-1:0] reg_addr,
  output logic [hbsfe_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [hbsfe_pkg::DATA_W-1:0] reg_rdata
);
  import hbsfe_pkg::*;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  hbsfe_pin_if p ();
  wire [NPIN-1:0] pins_raw = {addr_muxed, host_style, hw_control_mode,
    addr_in, bus_in, out_edge_select, host_select_n,
    serial_in_data_strobe_n, read_rw_select, shift_addr_strobe_n};

  hbsfe_pin_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins_raw(pins_raw),
    .p(p)
  );

  function automatic hbsfe_style_t style_of(input logic [1:0] code);
    if (code == STY_PIN_SERIAL) begin
      return STYLE_SERIAL;
    end else if (code == STY_PIN_PAIR) begin
      return STYLE_PAIR;
    end
    return STYLE_DS;
  endfunction

  // ---------------------------------------------------------------
  // Static configuration
  // ---------------------------------------------------------------
  // Straps are taken once, after the synchroniser has settled, and never
  // again; changing them later has no effect until the next reset.
  logic [1:0] settle_reg;
  logic cfg_done_reg;
  logic hw_reg;
  logic mux_reg;
  hbsfe_style_t style_reg;
  wire cfg_load = !cfg_done_reg && (settle_reg == CFG_SETTLE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 2'h0;
      cfg_done_reg <= 1'b0;
      hw_reg <= 1'b1;
      mux_reg <= 1'b0;
      style_reg <= STYLE_SERIAL;
    end else if (cfg_load) begin
      cfg_done_reg <= 1'b1;
      hw_reg <= p.lvl[PIN_HW];
      mux_reg <= p.lvl[PIN_MUX];
      style_reg <= style_of(p.lvl[PIN_STYLE +: 2]);
    end else if (!cfg_done_reg) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  wire is_serial = (style_reg == STYLE_SERIAL);
  wire is_pair = (style_reg == STYLE_PAIR);
  wire is_ds = (style_reg == STYLE_DS);
  wire is_par = is_pair || is_ds;
  // In hardware control mode every strobe is masked here.
  wire host_act = cfg_done_reg && !hw_reg && !p.lvl[PIN_SEL];
  wire [DATA_W-1:0] bus_s = p.lvl[PIN_AD +: DATA_W];
  wire [ADDR_W-1:0] apin_s = p.lvl[PIN_A +: ADDR_W];
  wire rw_s = p.lvl[PIN_RDRW];

  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  logic cmd_rw_reg;
  logic rise_d1_reg;

  wire ser_rise = host_act && is_serial && p.rise[PIN_SHIFT];
  wire [DATA_W-1:0] ser_word = {shift_reg[6:0], p.lvl[PIN_WRDS]};
  wire cmd_done = ser_rise && (bit_cnt_reg == SER_CMD_LAST);
  wire dat_done = ser_rise && (bit_cnt_reg == SER_LAST) && !cmd_rw_reg;

  // Multiplexed address phase uses the same pin fall in both styles.
  wire addr_latch = host_act && is_par && mux_reg &&
    p.fall[PIN_SHIFT];
  wire addr_pin_latch = host_act && is_par && !mux_reg &&
    (p.fall[PIN_WRDS] || (is_pair && p.fall[PIN_RDRW]));
  wire pair_rd = host_act && is_pair && p.fall[PIN_RDRW];
  wire pair_wr = host_act && is_pair && p.rise[PIN_WRDS];
  wire ds_rd = host_act && is_ds && p.fall[PIN_WRDS] && rw_s;
  wire ds_wr = host_act && is_ds && p.rise[PIN_WRDS] && !rw_s;
  wire rd_evt = (cmd_done && ser_word[CMD_RW_BIT]) || pair_rd || ds_rd;
  wire wr_evt = dat_done || pair_wr || ds_wr;

  wire [ADDR_W-1:0] addr_next = cmd_done ? ser_word[ADDR_W-1:0] :
    addr_latch ? bus_s[ADDR_W-1:0] :
    addr_pin_latch ? apin_s : reg_addr;
  wire [DATA_W-1:0] wdata_next = dat_done ? ser_word :
    (pair_wr || ds_wr) ? bus_s : reg_wdata;
  wire bus_oe_next = host_act && ((is_pair && !rw_s) ||
    (is_ds && rw_s && !p.lvl[PIN_WRDS]));

  // ---------------------------------------------------------------
  // Serial shifter
  // ---------------------------------------------------------------
  wire ser_data_ph = (bit_cnt_reg >= SER_HALF);
  wire ser_launch = p.lvl[PIN_EDGE] ? p.fall[PIN_SHIFT] :
    rise_d1_reg;
  wire [4:0] bit_cnt_next = !host_act ? SER_CNT_RST :
    (ser_rise && bit_cnt_reg != SER_BITS) ? bit_cnt_reg + 5'h01 :
    bit_cnt_reg;
  wire ser_on = host_act && is_serial;
  // Read data bits go out MSB first; the index is 15 minus the count.
  wire sdo_next = (!ser_on || !ser_data_ph || !cmd_rw_reg) ? 1'b0 :
    (ser_launch && bit_cnt_reg != SER_BITS) ?
    reg_rdata[~bit_cnt_reg[2:0]] : serial_out_line;
  wire sdo_oe_next = ser_on && ser_data_ph;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= SER_CNT_RST;
      shift_reg <= SER_SHIFT_RST;
      cmd_rw_reg <= 1'b0;
      rise_d1_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rise_d1_reg <= ser_rise;
      if (ser_rise) begin
        shift_reg <= {shift_reg[14:0], p.lvl[PIN_WRDS]};
      end
      if (cmd_done) begin
        cmd_rw_reg <= ser_word[CMD_RW_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr <= ADDR_RST;
      reg_wdata <= DATA_RST;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      bus_out <= DATA_RST;
      bus_oe <= 1'b0;
      serial_out_line <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      reg_addr <= addr_next;
      reg_wdata <= wdata_next;
      reg_write <= wr_evt;
      reg_read <= rd_evt;
      bus_out <= reg_rdata;
      bus_oe <= bus_oe_next;
      serial_out_line <= sdo_next;
      serial_out_oe <= sdo_oe_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_cmd_write;
    ser_rise && (bit_cnt_reg == SER_CMD_LAST) && !ser_word[CMD_RW_BIT];
  endsequence
  sequence s_drive_low;
    serial_out_oe && !serial_out_line;
  endsequence
  sequence s_hw_idle;
    cfg_done_reg && hw_reg;
  endsequence

  fall_launch_a: assert property (
    (ser_on && p.lvl[PIN_EDGE] && !p.fall[PIN_SHIFT] && cmd_rw_reg)
    |=> $stable(serial_out_line))
    else $error("serial output moved off a falling shift edge");
  rise_launch_a: assert property (
    (ser_on && !p.lvl[PIN_EDGE] && !rise_d1_reg && cmd_rw_reg)
    |=> $stable(serial_out_line))
    else $error("serial output moved off a rising shift edge");
  serial_sample_a: assert property (
    ser_rise |=> (shift_reg[0] == $past(p.lvl[PIN_WRDS])))
    else $error("serial input not sampled on rising edge");
  latch_addr_a: assert property (
    (host_act && is_pair && mux_reg && p.fall[PIN_SHIFT])
    |=> (reg_addr == $past(bus_s[ADDR_W-1:0])))
    else $error("address not taken on latch strobe fall");
  strobe_addr_a: assert property (
    (host_act && is_ds && mux_reg && p.fall[PIN_SHIFT])
    |=> (reg_addr == $past(bus_s[ADDR_W-1:0])))
    else $error("address not taken on address strobe fall");
  hw_ignore_a: assert property (
    s_hw_idle |=> (!reg_read && !reg_write && !bus_oe && !serial_out_oe))
    else $error("activity in hardware control mode");
  pair_write_a: assert property (
    pair_wr |=> (reg_write && reg_wdata == $past(bus_s)))
    else $error("write strobe rise did not capture data");
  ds_write_a: assert property (
    ds_wr |=> (reg_write && reg_wdata == $past(bus_s)))
    else $error("data strobe rise did not capture data");
  serial_hiz_a: assert property (
    (ser_on && bit_cnt_reg < SER_HALF) |=> !serial_out_oe)
    else $error("serial output driven during command byte");
  serial_low_a: assert property (
    s_cmd_write |=> ##1 s_drive_low ##1 (s_drive_low or !host_act))
    else $error("serial output not driven low in write data");
  cfg_fixed_a: assert property (
    cfg_done_reg |=> ($stable(style_reg) && $stable(mux_reg) &&
    $stable(hw_reg)))
    else $error("host style changed after configuration");
endmodule // hbsfe_top

// ===== testbench/hbsfe_host_model.sv
// Behavioural host processor that drives the front end's pins.
`timescale 1ns/1ps
module hbsfe_host_model (
  input wire logic clock,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic bus_oe,
  output logic host_select_n,
  output logic shift_addr_strobe_n,
  output logic read_rw_select,
  output logic serial_in_data_strobe_n,
  output logic [hbsfe_pkg::DATA_W-1:0] bus_in,
  output logic [hbsfe_pkg::ADDR_W-1:0] addr_in
);
  import hbsfe_pkg::*;
  // An undriven serial line reads as the inverse of its last level.
  wire sdo_seen = serial_out_oe ? serial_out_line : ~serial_out_line;
  // ---------------------------------------------------------------
  // Host bus cycles
  // ---------------------------------------------------------------
  // Released lines flip so that a stale level never passes for data.
  initial begin
    host_select_n = 1'b1;
    shift_addr_strobe_n = 1'b0;
    read_rw_select = 1'b1;
    serial_in_data_strobe_n = 1'b1;
    bus_in = 8'h00;
    addr_in = 5'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // The shift clock rests low in serial style; parallel strobes rest high.
  task automatic idle(input logic serial);
    shift_addr_strobe_n <= ~serial;
    read_rw_select <= 1'b1;
    serial_in_data_strobe_n <= 1'b1;
    host_select_n <= 1'b1;
  endtask
  task automatic ser(input logic [15:0] word, input logic edge_fall,
                     output logic [7:0] rdat, output logic [15:0] oe_v);
    rdat = 8'h00;
    host_select_n <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < 16; i++) begin
      serial_in_data_strobe_n <= word[15-i];
      wait_clk(4);
      shift_addr_strobe_n <= 1'b1;
      oe_v[15-i] = serial_out_oe;
      if (i > 7 && !edge_fall) rdat[15-i] = sdo_seen;
      wait_clk(4);
      shift_addr_strobe_n <= 1'b0;
      if (i > 7 && edge_fall) rdat[15-i] = sdo_seen;
    end
    wait_clk(4);
    host_select_n <= 1'b1;
    serial_in_data_strobe_n <= ~word[0];
    wait_clk(6);
  endtask
  task automatic par(input logic ds, input logic muxed, input logic wr,
                     input logic [7:0] a, input logic [7:0] d,
                     output logic oe);
    host_select_n <= 1'b0;
    addr_in <= a[4:0];
    if (ds) read_rw_select <= ~wr;
    wait_clk(4);
    if (muxed) begin
      bus_in <= a;
      shift_addr_strobe_n <= 1'b0;
      wait_clk(4);
      shift_addr_strobe_n <= 1'b1;
      wait_clk(4);
    end
    if (wr) bus_in <= d;
    if (wr || ds) serial_in_data_strobe_n <= 1'b0;
    else read_rw_select <= 1'b0;
    wait_clk(6);
    oe = bus_oe;
    serial_in_data_strobe_n <= 1'b1;
    if (!ds) read_rw_select <= 1'b1;
    wait_clk(4);
    host_select_n <= 1'b1;
    bus_in <= ~bus_in;
    wait_clk(4);
  endtask
endmodule // hbsfe_host_model

// ===== testbench/test_host_bus_strobe_front_end.sv
// Self-checking bench for the host bus strobe front end.
`timescale 1ns/1ps
module test_host_bus_strobe_front_end;
  import hbsfe_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic out_edge_select = 1'b1;
  logic hw_control_mode = 1'b0;
  logic [1:0] host_style = 2'h0;
  logic addr_muxed = 1'b0;
  logic [DATA_W-1:0] reg_rdata = 8'h00;
  logic host_select_n, shift_addr_strobe_n, read_rw_select;
  logic serial_in_data_strobe_n, bus_oe, serial_out_line, serial_out_oe;
  logic reg_write, reg_read;
  logic [DATA_W-1:0] bus_in, bus_out, reg_wdata, lw;
  logic [ADDR_W-1:0] addr_in, reg_addr, la;
  logic [7:0] wr_cnt = 8'h00;
  logic [7:0] rd_cnt = 8'h00;
  int errors = 0;
  int n_checks = 0;
  always #25 clock = ~clock;
  hbsfe_top dut_u (.clock(clock), .rst_n(rst_n),
    .host_select_n(host_select_n), .shift_addr_strobe_n(shift_addr_strobe_n),
    .read_rw_select(read_rw_select),
    .serial_in_data_strobe_n(serial_in_data_strobe_n),
    .out_edge_select(out_edge_select), .hw_control_mode(hw_control_mode),
    .host_style(host_style), .addr_muxed(addr_muxed), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .addr_in(addr_in),
    .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  hbsfe_host_model host_u (.clock(clock), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .bus_oe(bus_oe),
    .host_select_n(host_select_n), .shift_addr_strobe_n(shift_addr_strobe_n),
    .read_rw_select(read_rw_select),
    .serial_in_data_strobe_n(serial_in_data_strobe_n),
    .bus_in(bus_in), .addr_in(addr_in));
  // ---------------------------------------------------------------
  // Pulse capture, comparison and closing
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (reg_write === 1'b1) wr_cnt <= wr_cnt + 8'h01;
    if (reg_read === 1'b1) rd_cnt <= rd_cnt + 8'h01;
    if (reg_write === 1'b1 || reg_read === 1'b1) la <= reg_addr;
    if (reg_write === 1'b1) lw <= reg_wdata;
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Straps are set while reset is low, so each style gets a fresh boot; t_par then moves host_style after boot.
  task automatic boot(input logic [1:0] sty, input logic mux, input logic hw);
    rst_n <= 1'b0;
    host_style <= sty;
    addr_muxed <= mux;
    hw_control_mode <= hw;
    host_u.idle(sty == 2'h0);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_ser_write();
    logic [7:0] w0, rdat;
    logic [15:0] oe_v;
    boot(2'h0, 1'b0, 1'b0);
    w0 = wr_cnt;
    host_u.ser(16'h6AA5, 1'b1, rdat, oe_v);
    check(16'(wr_cnt - w0), 16'h0001);
    check(16'(la), 16'h000A);
    check(16'(lw), 16'h00A5);
    check(oe_v, 16'h00FF);
    check(16'(rdat), 16'h0000);
    $display("test serial write done");
  endtask
  task automatic t_ser_read(input logic edge_fall);
    logic [7:0] r0, w0, rdat;
    logic [15:0] oe_v;
    out_edge_select <= edge_fall;
    reg_rdata <= 8'h96;
    r0 = rd_cnt;
    w0 = wr_cnt;
    host_u.ser(16'h9500, edge_fall, rdat, oe_v);
    check(16'(rd_cnt - r0), 16'h0001);
    check(16'(wr_cnt - w0), 16'h0000);
    check(16'(la), 16'h0015);
    check(16'(rdat), 16'h0096);
    check(oe_v, 16'h00FF);
    $display("test serial read done, edge select %0b", edge_fall);
  endtask
  task automatic t_par(input logic ds, input logic mux, input logic [7:0] a,
                       input logic [7:0] d, input logic [4:0] ea);
    logic [7:0] w0, r0;
    logic oe;
    boot(ds ? (mux ? 2'h2 : 2'h3) : 2'h1, mux, 1'b0);
    host_style <= 2'h0;
    w0 = wr_cnt;
    host_u.par(ds, mux, 1'b1, a, d, oe);
    check(16'(wr_cnt - w0), 16'h0001);
    check(16'(la), 16'(ea));
    check(16'(lw), 16'(d));
    check(16'(oe), 16'h0000);
    reg_rdata <= ~d;
    r0 = rd_cnt;
    host_u.par(ds, mux, 1'b0, a, 8'h00, oe);
    check(16'(rd_cnt - r0), 16'h0001);
    check(16'(la), 16'(ea));
    check(16'(oe), 16'h0001);
    check({8'h00, bus_out}, {8'h00, ~d});
    $display("test parallel style %0b muxed %0b done", ds, mux);
  endtask
  task automatic t_hw();
    logic [7:0] w0, r0, rdat;
    logic [15:0] oe_v;
    logic oe;
    boot(2'h1, 1'b1, 1'b1);
    w0 = wr_cnt;
    r0 = rd_cnt;
    host_u.par(1'b0, 1'b1, 1'b1, 8'h05, 8'h11, oe);
    host_u.par(1'b0, 1'b1, 1'b0, 8'h05, 8'h00, oe);
    check(16'(oe), 16'h0000);
    boot(2'h0, 1'b0, 1'b1);
    host_u.ser(16'h9500, 1'b1, rdat, oe_v);
    check(16'(wr_cnt - w0), 16'h0000);
    check(16'(rd_cnt - r0), 16'h0000);
    check(oe_v, 16'h0000);
    $display("test hardware control done");
  endtask
  initial begin
    t_ser_write();
    t_ser_read(1'b1);
    t_ser_read(1'b0);
    t_par(1'b0, 1'b1, 8'hF3, 8'h3C, 5'h13);
    t_par(1'b1, 1'b1, 8'hEC, 8'hC3, 5'h0C);
    t_par(1'b1, 1'b0, 8'hFB, 8'h5A, 5'h1B);
    t_par(1'b0, 1'b0, 8'h0E, 8'h81, 5'h0E);
    t_hw();
    conclude();
  end
  // All scenarios take about 880 cycles; the limit leaves wide margin.
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule // test_host_bus_strobe_front_end
